// *** design/sprs_pkg.sv ***
// Notes on behaviour
// - Transaction is two bytes, full duplex
// - Command then data in; status then data out
// - Select fall starts frame, enables output
// - First output bit at first rising clock
// - Output changes only on rising clock
// - Input sampled on falling clock
// - Valid only with exactly sixteen sample edges
// - Write commits at select rising edge
// - Register captured while parity bit shifts
// - Output high impedance while select high
// - Five-bit field selects the register
// - Read flag one: ignore data, no change
// - Write returns old contents, stores new
// - Parity checked on writes only
// - First output byte is system status
package sprs_pkg;
    localparam int SPRS_FRAME_BITS  = 16;
    localparam int SPRS_CNT_W       = 5;
    localparam int SPRS_IDX_W       = 5;
    localparam int SPRS_DATA_W      = 8;
    localparam int SPRS_NUM_REGS    = 32;
    localparam int SPRS_STATUS_IDX  = 12;
    localparam int SPRS_CMD_RW_POS  = 7;
    localparam int SPRS_CMD_IDX_LSB = 2;
    localparam int SPRS_CMD_PAR_POS = 1;
    localparam logic [7:0] SPRS_REG_RESET = 8'h00;
    localparam int SPRS_PARITY_BITNUM = 7;

    typedef struct packed {
        logic       rdNotWr;
        logic [4:0] registerIndexField;
        logic       parity;
        logic       unused;
    } sprs_cmd_type;

    typedef struct packed {
        logic       wrEn;
        logic [4:0] idx;
        logic [7:0] data;
    } sprs_wr_type;
endpackage

// *** design/sprs_sync.sv ***
`timescale 1ns/1ns
// Two-flop synchroniser with a registered edge detector after the second stage
module sprs_sync
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic resetValue,
    // Pin in
    input  wire logic pinIn,
    // Synchronised level and edges
    output logic      syncOut,
    output logic      riseOut,
    output logic      fallOut
);
    logic stage1_reg;
    logic stage2_reg;
    logic prev_reg;

    // Only stage2 reads stage1
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            stage1_reg <= resetValue;
            stage2_reg <= resetValue;
            prev_reg   <= resetValue;
        end
        else
        begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            prev_reg   <= stage2_reg;
        end
    end

    assign syncOut = stage2_reg;
    assign riseOut = stage2_reg & ~prev_reg;
    assign fallOut = ~stage2_reg & prev_reg;
endmodule

// *** design/sprs_slave.sv ***
`timescale 1ns/1ns
// SPI register access slave; registers live here as an array
module sprs_slave
(
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                srst,
    // SPI pins
    input  wire logic                slaveSelect_n,
    input  wire logic                serial_shift_clock,
    input  wire logic                mosi,
    output logic                     misoOut,
    output logic                     misoOe,
    // Status and committed writes
    input  wire logic [7:0]          systemStatus,
    output logic                     writeStrobe,
    output logic [4:0]               writeIndex,
    output logic [7:0]               writeData,
    output logic [255:0]             regsFlat
);
    // Synchronised pins and their edges
    logic                 ssSync;
    logic                 ssRise;
    logic                 ssFall;
    logic                 sckSync;
    logic                 sckRise;
    logic                 sckFall;
    logic                 mosiSync;

    // Frame state, shifters and the register array
    logic                 active_reg;
    logic [4:0]           bitCnt_reg;
    logic [15:0]          rx_reg;
    logic [7:0]           txShift_reg;
    logic                 misoOut_reg;
    logic [7:0]           captured_reg;
    logic [7:0]           regs_reg [0:31];
    sprs_pkg::sprs_wr_type wr_reg;

    // Every pin passes two flops; idle levels preload the detectors so reset makes no false edge
    sprs_sync uSs
    (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .resetValue (1'b1),
        .pinIn      (slaveSelect_n),
        .syncOut    (ssSync),
        .riseOut    (ssRise),
        .fallOut    (ssFall)
    );

    sprs_sync uSck
    (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .resetValue (1'b0),
        .pinIn      (serial_shift_clock),
        .syncOut    (sckSync),
        .riseOut    (sckRise),
        .fallOut    (sckFall)
    );

    sprs_sync uMosi
    (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .resetValue (1'b0),
        .pinIn      (mosi),
        .syncOut    (mosiSync),
        .riseOut    (),
        .fallOut    ()
    );

    // Decode of the received command byte
    sprs_pkg::sprs_cmd_type cmd;
    wire logic [6:0] cmdParityBits = {cmd.rdNotWr, cmd.registerIndexField, cmd.parity};
    wire logic       parityOk      = ~^cmdParityBits;
    wire logic       countOk       = (bitCnt_reg == 5'(sprs_pkg::SPRS_FRAME_BITS));
    wire logic       sampleEdge    = active_reg & sckFall & ~ssSync;
    wire logic       shiftEdge     = active_reg & sckRise & ~ssSync;
    wire logic [15:0] rxNext       = {rx_reg[14:0], mosiSync};
    wire logic       atParity      = (bitCnt_reg == 5'(sprs_pkg::SPRS_PARITY_BITNUM - 1)) & sampleEdge;
    wire logic       handover      = (bitCnt_reg == 5'(sprs_pkg::SPRS_DATA_W - 1)); // Last status bit leaves here
    wire logic [7:0] txShiftNext   = handover ? captured_reg : {txShift_reg[6:0], 1'b0};
    wire logic       commitOk      = ssRise & active_reg & countOk & ~cmd.rdNotWr & parityOk;
    assign cmd = rx_reg[15:8];

    // Frame control and input shifting; sample on serial clock falls
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            active_reg <= 1'b0;
            bitCnt_reg <= 5'h00;
            rx_reg     <= 16'h0000;
        end
        else if (ssFall)
        begin
            active_reg <= 1'b1;
            bitCnt_reg <= 5'h00;
            rx_reg     <= 16'h0000;
        end
        else if (ssRise)
            active_reg <= 1'b0;
        else if (sampleEdge)
        begin
            rx_reg <= rxNext;
            if (bitCnt_reg != 5'h1F)
                bitCnt_reg <= bitCnt_reg + 5'h01;               // saturates so extra edges still fail
        end
    end

    // Output path: status byte first, then the register held aside at the parity bit
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            txShift_reg <= 8'h00;
            misoOut_reg <= 1'b0;
        end
        else if (ssFall)
            txShift_reg <= systemStatus;
        else if (shiftEdge)
        begin
            misoOut_reg <= txShift_reg[7];
            txShift_reg <= txShiftNext;
        end
    end

    // Loading the shifter at the parity bit would lose the last status bit, so hold the register aside
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            captured_reg <= 8'h00;
        else if (atParity)
            captured_reg <= regs_reg[rxNext[5:1]];
    end

    // Register array and write commit at select rising edge
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            for (int i = 0; i < sprs_pkg::SPRS_NUM_REGS; i++)
                regs_reg[i] <= sprs_pkg::SPRS_REG_RESET;
            wr_reg <= '0;
        end
        else
        begin
            wr_reg.wrEn <= commitOk;
            if (commitOk)
            begin
                regs_reg[cmd.registerIndexField] <= rx_reg[7:0];
                wr_reg.idx  <= cmd.registerIndexField;
                wr_reg.data <= rx_reg[7:0];
            end
        end
    end

    // Flat view of the array for observers
    genvar g;
    generate
        for (g = 0; g < sprs_pkg::SPRS_NUM_REGS; g++)
        begin : gFlat
            assign regsFlat[g*8 +: 8] = regs_reg[g];
        end
    endgenerate

    // Pin drive: enable only while the frame is active
    assign misoOe      = active_reg & ~ssSync;
    assign misoOut     = misoOe ? misoOut_reg : 1'b0;
    assign writeStrobe = wr_reg.wrEn;
    assign writeIndex  = wr_reg.idx;
    assign writeData   = wr_reg.data;

    // Frame and write checks
    a_frame_length: assert property (@(posedge clk_sys) disable iff (srst)
        writeStrobe |-> $past(bitCnt_reg) == 5'h10)
        else $error("write committed with wrong edge count");
    a_count_saturates: assert property (@(posedge clk_sys) disable iff (srst)
        bitCnt_reg == 5'h1F && !ssFall |=> bitCnt_reg == 5'h1F)
        else $error("edge counter wrapped");
    a_count_restart: assert property (@(posedge clk_sys) disable iff (srst)
        ssFall |=> bitCnt_reg == 5'h00)
        else $error("edge counter not cleared at frame start");
    a_strobe_pulse: assert property (@(posedge clk_sys) disable iff (srst)
        writeStrobe |=> !writeStrobe)
        else $error("write strobe longer than one cycle");
    a_read_no_write: assert property (@(posedge clk_sys) disable iff (srst)
        writeStrobe |-> !$past(cmd.rdNotWr))
        else $error("read transaction wrote a register");
    a_parity_checked: assert property (@(posedge clk_sys) disable iff (srst)
        writeStrobe |-> $past(parityOk))
        else $error("write with bad parity committed");

    // Output path and write storage checks
    a_idle_highz: assert property (@(posedge clk_sys) disable iff (srst)
        ssSync |-> !misoOe && !misoOut)
        else $error("output driven while deselected");
    a_out_on_rise: assert property (@(posedge clk_sys) disable iff (srst)
        $changed(misoOut_reg) |-> $past(sckRise))
        else $error("output changed off rising clock");
    a_status_first: assert property (@(posedge clk_sys) disable iff (srst)
        ssFall |=> txShift_reg == $past(systemStatus))
        else $error("status byte not loaded at frame start");
    a_drive_on_start: assert property (@(posedge clk_sys) disable iff (srst)
        ssFall ##1 !ssSync |-> misoOe)
        else $error("output not enabled after select fall");
    a_write_stores: assert property (@(posedge clk_sys) disable iff (srst)
        writeStrobe |-> regs_reg[writeIndex] == writeData)
        else $error("write data not stored");
    a_capture_parity: assert property (@(posedge clk_sys) disable iff (srst)
        atParity |=> captured_reg == $past(regs_reg[rxNext[5:1]]))
        else $error("register not captured at parity bit");
    a_byte_handover: assert property (@(posedge clk_sys) disable iff (srst)
        shiftEdge && handover |=> txShift_reg == $past(captured_reg))
        else $error("register byte not handed to the shifter");

    // Main scenarios
    c_write: cover property (@(posedge clk_sys) writeStrobe);
    c_handover: cover property (@(posedge clk_sys) shiftEdge && handover);
    c_read_end: cover property (@(posedge clk_sys) ssRise && countOk && cmd.rdNotWr);
    c_bad_count: cover property (@(posedge clk_sys) ssRise && active_reg && !countOk);
    c_bad_parity: cover property (@(posedge clk_sys) ssRise && countOk && !cmd.rdNotWr && !parityOk);
endmodule

// *** test/sprs_master.sv ***
`timescale 1ns/1ns
// Behavioural SPI master; its clock stands still outside frames
module sprs_master
(
    // SPI pins
    output logic     ssN,
    output logic     sck,
    output logic     mosi,
    input  wire logic miso
);
    // Idle: select high, clock low
    initial
    begin
        ssN  = 1'b1;
        sck  = 1'b0;
        mosi = 1'b0;
    end

    // MOSI changes with the rising edge so it is stable over the falling sample edge
    task automatic frame(input logic [15:0] tx, input int nBits, output logic [15:0] rx);
        rx  = 16'h0000;
        ssN = 1'b0;
        #83;
        for (int i = 0; i < nBits; i++)
        begin
            sck  = 1'b1;
            mosi = tx[15 - (i % 16)];
            #80;
            sck = 1'b0;
            rx  = {rx[14:0], miso};
            #80;
        end
        ssN  = 1'b1;
        mosi = ~mosi; // Released line must not keep its last value
        #160;
    endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    logic         clk_sys = 1'b0;
    logic         srst = 1'b1;
    logic         ssN, sck, mosi, misoOut, misoOe, misoHold, misoWire, writeStrobe;
    logic [7:0]   systemStatus = 8'h00;
    logic [4:0]   writeIndex, lastIdx;
    logic [7:0]   writeData, lastData, d;
    logic [255:0] regsFlat;
    logic [15:0]  rx;
    int           n_errors = 0, checks_done = 0, nStrobe = 0, s0;

    always #2 clk_sys = ~clk_sys;
    // Undriven wire shows the inverse of its last value, never a lucky match
    always @(posedge clk_sys) if (misoOe === 1'b1) misoHold <= misoOut;
    assign misoWire = (misoOe === 1'b1) ? misoOut : ~misoHold;
    // Count committed writes
    always @(posedge clk_sys)
    begin
        if (writeStrobe === 1'b1)
        begin
            nStrobe++;
            lastIdx = writeIndex;
            lastData = writeData;
        end
    end

    sprs_master i_master (.ssN(ssN), .sck(sck), .mosi(mosi), .miso(misoWire));
    sprs_slave i_dut (.clk_sys(clk_sys), .srst(srst), .slaveSelect_n(ssN), .serial_shift_clock(sck), .mosi(mosi),
        .misoOut(misoOut), .misoOe(misoOe), .systemStatus(systemStatus), .writeStrobe(writeStrobe),
        .writeIndex(writeIndex), .writeData(writeData), .regsFlat(regsFlat));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Command word with parity, optionally spoilt
    function automatic logic [15:0] word(input logic rw, input logic [4:0] idx, input logic [7:0] dat, input logic bad);
        return {rw, idx, ^{rw, idx} ^ bad, 1'b0, dat};
    endfunction

    task automatic xfer(input logic rw, input logic [4:0] idx, input logic [7:0] dat, input logic bad, input int n);
        s0 = nStrobe;
        i_master.frame(word(rw, idx, dat, bad), n, rx);
    endtask

    task automatic t_reset;
        check({15'h0000, misoOe}, 16'h0000, "oe after reset");
        check({8'h00, regsFlat[255:248] | regsFlat[7:0] | regsFlat[103:96]}, 16'h0000, "reset regs");
        $display("test reset done");
    endtask

    // Boundary indices and the status index; write then read back
    task automatic t_write_read;
        logic [4:0] idxList [3] = '{5'h00, 5'h0C, 5'h1F};
        for (int k = 0; k < 3; k++)
        begin
            d = {3'h5, idxList[k]};
            @(posedge clk_sys) #1 systemStatus <= 8'h3C ^ d;
            xfer(1'b0, d[4:0], d, 1'b0, 16);
            check(rx, {8'h3C ^ d, 8'h00}, "write reply");
            check(16'(nStrobe - s0), 16'h0001, "one strobe");
            check({3'h0, lastIdx, lastData}, {3'h0, d[4:0], d}, "strobe idx data");
            check({8'h00, regsFlat[d[4:0]*8+:8]}, {8'h00, d}, "stored");
            xfer(1'b1, d[4:0], 8'h5A, 1'b0, 16);
            check(rx, {8'h3C ^ d, d}, "read reply");
            check({8'h00, regsFlat[d[4:0]*8+:8]}, {8'h00, d}, "read keeps");
            check(16'(nStrobe - s0), 16'h0000, "read no strobe");
            check({15'h0000, misoOe}, 16'h0000, "oe idle");
        end
        $display("test write_read done");
    endtask

    // Bad parity and wrong edge counts must leave the register alone
    task automatic t_discard;
        xfer(1'b0, 5'h07, 8'h11, 1'b0, 16);
        xfer(1'b0, 5'h07, 8'h22, 1'b1, 16);
        check({8'h00, regsFlat[63:56]}, 16'h0011, "bad parity");
        check(16'(nStrobe - s0), 16'h0000, "bad parity strobe");
        xfer(1'b1, 5'h07, 8'h00, 1'b1, 16);
        check({8'h00, rx[7:0]}, 16'h0011, "read ignores parity");
        for (int k = 0; k < 2; k++)
        begin
            xfer(1'b0, 5'h07, 8'h44, 1'b0, 15 + 2 * k);
            check({8'h00, regsFlat[63:56]}, 16'h0011, "count kept reg");
            check(16'(nStrobe - s0), 16'h0000, "count strobe");
        end
        xfer(1'b0, 5'h07, 8'h33, 1'b0, 16);
        check({8'h00, regsFlat[63:56]}, 16'h0033, "recovers");
        $display("test discard done");
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Twelve frames of about 3 us each fit well inside this span
    initial
    begin
        #200000;
        n_errors++;
        wrap_up();
    end

    initial
    begin
        repeat (16) @(posedge clk_sys);
        #1 srst = 1'b0;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_write_read();
        t_discard();
        wrap_up();
    end
endmodule
